// ### decoder_pkg.sv
// Address map constants for the processor memory address decoder
package decoder_pkg;
  localparam logic [15:0] FLASH_LAST = 16'h7fff;
  localparam logic [15:0] OVERLAY_LAST = 16'h05ff;
  localparam logic [15:0] FIRST_RAM_BLOCK_LAST = 16'h03ff;
  localparam logic [15:0] SECOND_RAM_BLOCK_FIRST = 16'h0400;
  localparam logic [15:0] SECOND_RAM_BLOCK_LAST = 16'h05ff;
  localparam logic [15:0] SHADOW_BASE = 16'h8000;
  localparam logic [15:0] SHADOW_LAST = 16'h85ff;
  localparam logic [15:0] PERIPH_FIRST = 16'hf000;
  localparam logic [7:0] SFR_FIRST = 8'h80;
  localparam int FIRST_RAM_BLOCK_BYTES = 1024;
  localparam int SECOND_RAM_BLOCK_BYTES = 512;
  localparam int IRAM_BYTES = 256;
  localparam int FETCH_BYTES = 4;
  localparam int PERIPH_WAIT_CYCLES = 1;
  localparam logic [7:0] REG_BANK_LAST = 8'h1f;
  localparam logic [7:0] BIT_AREA_LAST = 8'h2f;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic overlay_reset = 1'b0;
endpackage : decoder_pkg

// ### byte_ram.sv
// Single-port byte memory in flip-flops with a registered read
`timescale 1ns/1ps
module byte_ram #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  // Clock
  input wire logic clk,
  // Access port
  input wire logic wr_en,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= mem[addr];
  end
endmodule : byte_ram

// ### cpu_memory_address_decoder.sv
// Address decoder steering the four processor buses to their targets
`timescale 1ns/1ps
module cpu_memory_address_decoder
  import decoder_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Mode control
  input wire logic overlay_enable,
  // Program fetch bus
  input wire logic fetch_req,
  input wire logic [15:0] fetch_addr,
  output logic fetch_valid,
  output logic [7:0] fetch_data,
  // Flash port, one word of four bytes
  output logic flash_req,
  output logic [12:0] flash_word_addr,
  input wire logic flash_valid,
  input wire logic [8*FETCH_BYTES-1:0] flash_rdata,
  // External data bus
  input wire logic xdata_req,
  input wire logic xdata_we,
  input wire logic [15:0] xdata_addr,
  input wire logic [7:0] xdata_wdata,
  output logic xdata_valid,
  output logic [7:0] xdata_rdata,
  // Peripheral register port on the external data space
  output logic xperiph_req,
  output logic xperiph_we,
  output logic [15:0] xperiph_addr,
  output logic [7:0] xperiph_wdata,
  input wire logic [7:0] xperiph_rdata,
  // Direct register bus
  input wire logic sfr_req,
  input wire logic sfr_we,
  input wire logic sfr_bit_we,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic sfr_valid,
  output logic [7:0] sfr_rdata,
  // Register port on the direct space
  output logic periph_sfr_req,
  output logic periph_sfr_we,
  output logic periph_sfr_bit_we,
  output logic [7:0] periph_sfr_addr,
  output logic [7:0] periph_sfr_wdata,
  input wire logic [7:0] periph_sfr_rdata,
  // Scratch RAM bus
  input wire logic iram_req,
  input wire logic iram_we,
  input wire logic [7:0] iram_addr,
  input wire logic [7:0] iram_wdata,
  output logic iram_valid,
  output logic [7:0] iram_rdata,
  output logic iram_region_bank,
  output logic iram_region_bit,
  output logic sfr_bit_capable
);
  // ==========================================================
  // Decode functions
  function automatic logic is_first_ram_block(input logic [15:0] a);
    is_first_ram_block = (a <= FIRST_RAM_BLOCK_LAST) ||
      (a >= SHADOW_BASE && a <= (SHADOW_BASE | FIRST_RAM_BLOCK_LAST));
  endfunction : is_first_ram_block

  function automatic logic is_second_ram_block(input logic [15:0] a);
    is_second_ram_block = (a >= SECOND_RAM_BLOCK_FIRST && a <= SECOND_RAM_BLOCK_LAST) ||
      (a >= (SHADOW_BASE | SECOND_RAM_BLOCK_FIRST) && a <= SHADOW_LAST);
  endfunction : is_second_ram_block

  // ==========================================================
  // Mode register
  logic overlay;
  always_ff @(posedge clk) begin
    if (reset) begin
      overlay <= overlay_reset;
    end else begin
      overlay <= overlay_enable;
    end
  end

  // ==========================================================
  // Shared RAM blocks, arbitrated: data bus first
  logic x_first_ram_block, x_second_ram_block, x_periph;
  logic f_ovl, f_flash;
  assign x_first_ram_block = is_first_ram_block(xdata_addr);
  assign x_second_ram_block = is_second_ram_block(xdata_addr);
  assign x_periph = xdata_addr >= PERIPH_FIRST;
  assign f_ovl = overlay && fetch_addr <= OVERLAY_LAST;
  assign f_flash = !f_ovl && fetch_addr <= FLASH_LAST;

  logic x_busy;
  logic use_x_ram;
  logic fetch_ram_go;
  assign use_x_ram = xdata_req && !x_busy && (x_first_ram_block || x_second_ram_block);
  assign fetch_ram_go = fetch_req && f_ovl && !use_x_ram;

  logic [15:0] ram_addr;
  assign ram_addr = use_x_ram ? xdata_addr : fetch_addr;
  logic first_ram_block_we, second_ram_block_we;
  assign first_ram_block_we = use_x_ram && xdata_we && x_first_ram_block;
  assign second_ram_block_we = use_x_ram && xdata_we && x_second_ram_block;
  logic [9:0] first_ram_block_idx;
  logic [8:0] second_ram_block_idx;
  assign first_ram_block_idx = ram_addr[9:0];
  assign second_ram_block_idx = 9'(ram_addr[10:0] - SECOND_RAM_BLOCK_FIRST[10:0]);
  logic [7:0] first_ram_block_q, second_ram_block_q;

  byte_ram #(.DEPTH(FIRST_RAM_BLOCK_BYTES), .AW(10)) u_first_ram_block (
    .clk(clk), .wr_en(first_ram_block_we), .addr(first_ram_block_idx),
    .wr_data(xdata_wdata), .rd_data(first_ram_block_q)
  );
  byte_ram #(.DEPTH(SECOND_RAM_BLOCK_BYTES), .AW(9)) u_second_ram_block (
    .clk(clk), .wr_en(second_ram_block_we), .addr(second_ram_block_idx),
    .wr_data(xdata_wdata), .rd_data(second_ram_block_q)
  );

  // ==========================================================
  // Program fetch bus with four-byte line
  logic [12:0] line_tag;
  logic line_ok;
  logic [8*FETCH_BYTES-1:0] line_data;
  logic flash_wait;
  logic ovl_pend, ovl_sel1;

  always_ff @(posedge clk) begin
    if (reset) begin
      flash_req <= 1'b0;
      flash_word_addr <= 13'h0000;
      flash_wait <= 1'b0;
      line_ok <= 1'b0;
      line_tag <= 13'h0000;
      line_data <= '0;
    end else begin
      flash_req <= 1'b0;
      if (flash_wait && flash_valid) begin
        flash_wait <= 1'b0;
        line_ok <= 1'b1;
        line_data <= flash_rdata;
      end else if (fetch_req && f_flash && !flash_wait &&
                   !(line_ok && line_tag == fetch_addr[14:2])) begin
        flash_req <= 1'b1;
        flash_word_addr <= fetch_addr[14:2];
        line_tag <= fetch_addr[14:2];
        line_ok <= 1'b0;
        flash_wait <= 1'b1;
      end
    end
  end

  logic line_hit;
  assign line_hit = fetch_req && f_flash && line_ok &&
    line_tag == fetch_addr[14:2];

  always_ff @(posedge clk) begin
    if (reset) begin
      ovl_pend <= 1'b0;
      ovl_sel1 <= 1'b0;
    end else begin
      ovl_pend <= fetch_ram_go && !ovl_pend;
      ovl_sel1 <= is_second_ram_block(fetch_addr);
    end
  end

  // Read only: the fetch bus has no write path
  always_ff @(posedge clk) begin
    if (reset) begin
      fetch_valid <= 1'b0;
      fetch_data <= READ_ZERO;
    end else begin
      fetch_valid <= 1'b0;
      if (ovl_pend) begin
        fetch_valid <= 1'b1;
        fetch_data <= ovl_sel1 ? second_ram_block_q : first_ram_block_q;
      end else if (line_hit) begin
        fetch_valid <= 1'b1;
        fetch_data <= line_data[8*fetch_addr[1:0] +: 8];
      end else if (fetch_req && !f_flash && !f_ovl) begin
        fetch_valid <= 1'b1;
        fetch_data <= READ_ZERO;
      end
    end
  end

  // ==========================================================
  // External data bus
  logic [1:0] x_kind;
  logic x_wait;
  always_ff @(posedge clk) begin
    if (reset) begin
      x_busy <= 1'b0;
      x_kind <= 2'h0;
      xperiph_req <= 1'b0;
      xperiph_we <= 1'b0;
      xperiph_addr <= 16'h0000;
      xperiph_wdata <= 8'h00;
    end else begin
      xperiph_req <= 1'b0;
      if (x_busy) begin
        if (x_kind != 2'h3 || x_wait) begin
          x_busy <= 1'b0;
        end
      end else if (xdata_req) begin
        x_busy <= 1'b1;
        x_kind <= x_first_ram_block ? 2'h1 : x_second_ram_block ? 2'h2 :
          x_periph ? 2'h3 : 2'h0;
        if (x_periph) begin
          xperiph_req <= 1'b1;
          xperiph_we <= xdata_we;
          xperiph_addr <= xdata_addr;
          xperiph_wdata <= xdata_wdata;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      x_wait <= 1'b0;
    end else begin
      x_wait <= xperiph_req;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      xdata_valid <= 1'b0;
      xdata_rdata <= READ_ZERO;
    end else begin
      xdata_valid <= 1'b0;
      if (x_busy && x_kind != 2'h3) begin
        xdata_valid <= 1'b1;
        xdata_rdata <= x_kind == 2'h1 ? first_ram_block_q :
          x_kind == 2'h2 ? second_ram_block_q : READ_ZERO;
      end else if (x_wait) begin
        xdata_valid <= 1'b1;
        xdata_rdata <= xperiph_rdata;
      end
    end
  end

  // ==========================================================
  // Direct register bus
  always_ff @(posedge clk) begin
    if (reset) begin
      periph_sfr_req <= 1'b0;
      periph_sfr_we <= 1'b0;
      periph_sfr_bit_we <= 1'b0;
      periph_sfr_addr <= 8'h00;
      periph_sfr_wdata <= 8'h00;
      sfr_bit_capable <= 1'b0;
    end else begin
      periph_sfr_req <= sfr_req && sfr_addr >= SFR_FIRST;
      periph_sfr_we <= sfr_we;
      periph_sfr_bit_we <= sfr_bit_we &&
        sfr_addr[2:0] == 3'h0;
      periph_sfr_addr <= sfr_addr;
      periph_sfr_wdata <= sfr_wdata;
      sfr_bit_capable <= sfr_addr[7] && sfr_addr[2:0] == 3'h0;
    end
  end

  logic sfr_pend, sfr_hit;
  always_ff @(posedge clk) begin
    if (reset) begin
      sfr_pend <= 1'b0;
      sfr_hit <= 1'b0;
      sfr_valid <= 1'b0;
      sfr_rdata <= READ_ZERO;
    end else begin
      sfr_pend <= sfr_req;
      sfr_hit <= sfr_addr >= SFR_FIRST;
      sfr_valid <= sfr_pend;
      sfr_rdata <= sfr_hit ? periph_sfr_rdata : READ_ZERO;
    end
  end

  // ==========================================================
  // Scratch RAM: lower and upper halves in one array
  logic [7:0] iram_q;
  byte_ram #(.DEPTH(IRAM_BYTES), .AW(8)) u_iram (
    .clk(clk), .wr_en(iram_req && iram_we), .addr(iram_addr),
    .wr_data(iram_wdata), .rd_data(iram_q)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      iram_valid <= 1'b0;
      iram_region_bank <= 1'b0;
      iram_region_bit <= 1'b0;
    end else begin
      iram_valid <= iram_req;
      iram_region_bank <= iram_addr <= REG_BANK_LAST;
      iram_region_bit <= iram_addr > REG_BANK_LAST &&
        iram_addr <= BIT_AREA_LAST;
    end
  end
  assign iram_rdata = iram_q;
endmodule : cpu_memory_address_decoder

// ### decoder_properties.sv
// Port timing checker for the address decoder
`timescale 1ns/1ps
module decoder_properties
  import decoder_pkg::*;
(
  // Clock, reset, fetch side
  input wire logic clk,
  input wire logic reset,
  input wire logic fetch_req,
  input wire logic [15:0] fetch_addr,
  input wire logic fetch_valid,
  input wire logic [7:0] fetch_data,
  input wire logic flash_req,
  input wire logic [12:0] flash_word_addr,
  // Data side
  input wire logic xdata_req,
  input wire logic [15:0] xdata_addr,
  input wire logic xdata_valid,
  input wire logic xperiph_req,
  input wire logic [15:0] xperiph_addr,
  input wire logic sfr_req,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_valid,
  input wire logic periph_sfr_req,
  input wire logic [7:0] periph_sfr_addr,
  input wire logic periph_sfr_bit_we,
  input wire logic iram_req,
  input wire logic iram_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ==========================================
  // Assertions
  AST_FLASH_WORD: assert property (
    flash_req |-> flash_word_addr == fetch_addr[14:2])
    else $error("flash word address wrong");
  AST_FLASH_RANGE: assert property (
    flash_req |-> !fetch_addr[15]) else $error("flash read out of range");
  AST_FETCH_HOLE: assert property (
    $rose(fetch_req) && fetch_addr[15] |=> fetch_valid && fetch_data == 8'h00)
    else $error("unmapped fetch wrong");
  AST_SFR_ANSWER: assert property (
    sfr_req |-> ##2 sfr_valid) else $error("direct answer late");
  AST_SFR_ROUTE: assert property (
    sfr_req && sfr_addr[7] |=>
      periph_sfr_req && periph_sfr_addr == $past(sfr_addr))
    else $error("direct access not routed");
  AST_SFR_SPACE: assert property (
    periph_sfr_req |-> periph_sfr_addr[7]) else $error("direct below 0x80");
  AST_BIT_ALIGN: assert property (
    periph_sfr_bit_we |-> periph_sfr_addr[2:0] == 3'h0)
    else $error("bit write on unaligned byte");
  AST_IRAM_ANSWER: assert property (
    iram_req |=> iram_valid) else $error("scratch answer late");
  AST_XRAM_CYCLES: assert property (
    $rose(xdata_req) && xdata_addr < 16'h0600 |=> !xdata_valid ##1 xdata_valid)
    else $error("data RAM access timing");
  AST_XPER_CYCLES: assert property (
    $rose(xdata_req) && xdata_addr >= PERIPH_FIRST |=>
      !xdata_valid [*2] ##1 xdata_valid) else $error("register access timing");
  AST_XPER_ADDR: assert property (
    xperiph_req |-> xperiph_addr >= PERIPH_FIRST)
    else $error("register access outside window");
endmodule : decoder_properties

bind cpu_memory_address_decoder decoder_properties chk_i (.*);

// ### target_model.sv
// Flash and register targets behind the decoder
`timescale 1ns/1ps
module target_model (
  // Clock
  input wire logic clk,
  // Flash port
  input wire logic flash_req,
  input wire logic [12:0] flash_word_addr,
  output logic flash_valid = 1'b0,
  output logic [31:0] flash_rdata = '0,
  // Register ports
  input wire logic xperiph_req,
  input wire logic xperiph_we,
  input wire logic [15:0] xperiph_addr,
  input wire logic [7:0] xperiph_wdata,
  output logic [7:0] xperiph_rdata = '0,
  input wire logic periph_sfr_req,
  input wire logic periph_sfr_we,
  input wire logic [7:0] periph_sfr_addr,
  input wire logic [7:0] periph_sfr_wdata,
  output logic [7:0] periph_sfr_rdata
);
  logic [7:0] xmem [256] = '{default: 8'h00};
  logic [7:0] smem [256] = '{default: 8'h00};
  logic [12:0] wa = '0;
  logic [14:0] fa;
  logic slow = 1'b0;
  int wait_n = 0;
  // ==========================================
  // Flash, answering fast and slow in turn
  always @(posedge clk) begin
    flash_valid <= 1'b0;
    flash_rdata <= ~flash_rdata;
    if (flash_req) begin
      wa <= flash_word_addr;
      wait_n <= slow ? 4 : 1;
      slow <= ~slow;
    end else if (wait_n > 0) begin
      wait_n <= wait_n - 1;
      if (wait_n == 1) begin
        flash_valid <= 1'b1;
        for (int k = 0; k < 4; k++) begin
          fa = {wa, 2'(k)};
          flash_rdata[8*k+:8] <= fa[7:0] ^ {1'b0, fa[14:8]};
        end
      end
    end
  end
  // ==========================================
  // Direct registers answer within the request cycle
  always_comb begin
    periph_sfr_rdata = ~smem[periph_sfr_addr];
    if (periph_sfr_req) begin
      periph_sfr_rdata = smem[periph_sfr_addr];
    end
  end
  // Data space registers, data valid only after a request
  always @(posedge clk) begin
    xperiph_rdata <= ~xperiph_rdata;
    if (xperiph_req && xperiph_we) xmem[xperiph_addr[7:0]] <= xperiph_wdata;
    if (xperiph_req) xperiph_rdata <= xmem[xperiph_addr[7:0]];
    if (periph_sfr_req && periph_sfr_we)
      smem[periph_sfr_addr] <= periph_sfr_wdata;
  end
endmodule : target_model

// ### tb_cpu_memory_address_decoder.sv
// Self-checking bench for the address decoder
`timescale 1ns/1ps
module tb_cpu_memory_address_decoder;
  import decoder_pkg::*;
  logic clk = '0, reset = '1, overlay_enable = '0;
  logic fetch_req = '0, xdata_req = '0, xdata_we = '0, sfr_req = '0;
  logic sfr_we = '0, sfr_bit_we = '0, iram_req = '0, iram_we = '0;
  logic [15:0] fetch_addr = '0, xdata_addr = '0;
  logic [7:0] xdata_wdata = '0, sfr_addr = '0, sfr_wdata = '0;
  logic [7:0] iram_addr = '0, iram_wdata = '0;
  logic fetch_valid, flash_req, flash_valid, xdata_valid, xperiph_req;
  logic xperiph_we, sfr_valid, periph_sfr_req, periph_sfr_we, iram_valid;
  logic periph_sfr_bit_we, iram_region_bank, iram_region_bit, sfr_bit_capable;
  logic [7:0] fetch_data, xdata_rdata, xperiph_wdata, xperiph_rdata;
  logic [7:0] sfr_rdata, periph_sfr_addr, periph_sfr_wdata;
  logic [7:0] periph_sfr_rdata, iram_rdata;
  logic [12:0] flash_word_addr;
  logic [31:0] flash_rdata;
  logic [15:0] xperiph_addr;
  int n_fail = 0, total_checks = 0, cyc = 0;
  cpu_memory_address_decoder dut (.*);
  target_model partner (.*);
  always #4 clk = ~clk;
  // ==========================================
  // Helpers
  function automatic logic [7:0] fb(input logic [15:0] a);
    return a[7:0] ^ {1'b0, a[14:8]};
  endfunction : fb
  task automatic complete_run;
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic await(ref logic v, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (v !== 1'b1 && n < 40);
    if (v !== 1'b1) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end
  endtask : await
  task automatic fetch(input logic [15:0] a, input logic [7:0] e);
    int n;
    @(negedge clk);
    fetch_req = 1'b1;
    fetch_addr = a;
    await(fetch_valid, n);
    fetch_req = 1'b0;
    chk(fetch_data, e);
  endtask : fetch
  task automatic xacc(input logic w, input logic [15:0] a,
      input logic [7:0] d, input logic [7:0] e, input int c);
    int n;
    @(negedge clk);
    xdata_req = 1'b1;
    xdata_we = w;
    xdata_addr = a;
    xdata_wdata = d;
    await(xdata_valid, n);
    xdata_req = 1'b0;
    chk(8'(n), 8'(c));
    if (!w) chk(xdata_rdata, e);
  endtask : xacc
  task automatic sacc(input logic w, input logic b, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] r);
    int n;
    @(negedge clk);
    {sfr_req, sfr_we, sfr_bit_we, sfr_addr, sfr_wdata} = {1'b1, w, b, a, d};
    @(negedge clk);
    sfr_req = 1'b0;
    await(sfr_valid, n);
    r = sfr_rdata;
  endtask : sacc
  task automatic iacc(input logic w, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] r);
    int n;
    @(negedge clk);
    {iram_req, iram_we, iram_addr, iram_wdata} = {1'b1, w, a, d};
    await(iram_valid, n);
    iram_req = 1'b0;
    r = iram_rdata;
  endtask : iacc
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  // ==========================================
  // Tests
  initial begin
    logic [15:0] a;
    logic [7:0] d, r, a8;
    void'($urandom(32'h817a2a12));
    repeat (5) @(negedge clk);
    reset = 1'b0;
    for (int i = 0; i < 10; i++) begin
      a = (i < 2) ? 16'h7ffc + 16'(i * 3) : 16'($urandom) & 16'h7fff;
      fetch(a, fb(a));
      fetch(a ^ 16'h0001, fb(a ^ 16'h0001));
    end
    fetch(16'h8000, 8'h00);
    fetch(16'hffff, 8'h00);
    $display("fetch test done");
    for (int i = 0; i < 8; i++) begin
      a = (i < 3) ? 16'h03ff + 16'(i) * 16'h0100 : 16'($urandom % 1536);
      a = (i == 1) ? 16'h0400 : a;
      d = 8'($urandom);
      xacc(1'b1, a, d, d, 2);
      xacc(1'b0, a | 16'h8000, 8'h00, d, 2);
    end
    xacc(1'b1, 16'h7000, 8'ha5, 8'h00, 2);
    xacc(1'b0, 16'h7000, 8'h00, 8'h00, 2);
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 16'hffff : 16'hf000 | 16'($urandom % 4096);
      d = 8'($urandom);
      xacc(1'b1, a, d, d, 3);
      xacc(1'b0, a, 8'h00, d, 3);
    end
    $display("data bus test done");
    @(negedge clk);
    overlay_enable = 1'b1;
    xacc(1'b1, 16'h0123, 8'h3c, 8'h00, 2);
    xacc(1'b1, 16'h05ff, 8'hc3, 8'h00, 2);
    fetch(16'h0123, 8'h3c);
    fetch(16'h05ff, 8'hc3);
    fetch(16'h0600, fb(16'h0600));
    overlay_enable = 1'b0;
    repeat (2) @(negedge clk);
    fetch(16'h0123, fb(16'h0123));
    $display("overlay test done");
    for (int i = 0; i < 4; i++) begin
      a8 = 8'h80 | 8'($urandom);
      d = 8'($urandom);
      sacc(1'b1, 1'b0, a8, d, r);
      sacc(1'b0, 1'b0, a8, 8'h00, r);
      chk(r, d);
    end
    sacc(1'b1, 1'b1, 8'h88, 8'h01, r);
    chk({7'h00, sfr_bit_capable}, 8'h01);
    sacc(1'b1, 1'b1, 8'h83, 8'h01, r);
    chk({7'h00, sfr_bit_capable}, 8'h00);
    sacc(1'b1, 1'b0, 8'h40, 8'h55, r);
    chk(r, 8'h00);
    chk({7'h00, sfr_bit_capable}, 8'h00);
    $display("direct bus test done");
    for (int i = 0; i < 8; i++) begin
      a8 = (i == 0) ? 8'h1f : (i == 1) ? 8'h20 : (i == 2) ? 8'h2f : 8'($urandom);
      d = 8'($urandom);
      iacc(1'b1, a8, d, r);
      iacc(1'b0, a8, 8'h00, r);
      chk(r, d);
      r = {6'h00, a8 <= 8'h1f, a8 >= 8'h20 && a8 <= 8'h2f};
      chk({6'h00, iram_region_bank, iram_region_bit}, r);
    end
    $display("scratch test done");
    complete_run();
  end
endmodule : tb_cpu_memory_address_decoder
